// file: lcd_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_ctrl_monitor (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic scl_i,
  input wire logic sda_oe_o,
  input wire logic [lcd_pkg::NUM_SEG-1:0] segment_out_o,
  input wire logic [lcd_pkg::NUM_COM-1:0] common_line_o,
  input wire logic ref_ext_div_o,
  input wire logic ref_int_div_o,
  input wire logic ref_boost_o,
  input wire logic booster_run_o,
  input wire logic mode_locked_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);
  wire logic [2:0] refs = {ref_ext_div_o, ref_int_div_o, ref_boost_o};
  // ======================================
  // Display outputs
  property p_com_onehot;
    $onehot0(common_line_o);
  endproperty
  a_com_onehot: assert property (p_com_onehot)
    else $error("common lines not one-hot");
  property p_seg_dark;
    (common_line_o == 4'h0)[*3] |-> segment_out_o == 40'h0;
  endproperty
  a_seg_dark: assert property (p_seg_dark)
    else $error("segments driven with outputs off");
  // ======================================
  // Reference select and mode lock
  property p_boost_ref;
    booster_run_o |-> ref_boost_o;
  endproperty
  a_boost_ref: assert property (p_boost_ref)
    else $error("booster runs without boost reference");
  property p_ref_on_ack;
    $changed(refs) && $past(rst_b_i, 4) |-> sda_oe_o;
  endproperty
  a_ref_on_ack: assert property (p_ref_on_ack)
    else $error("reference select changed outside a write");
  property p_lock_sticky;
    mode_locked_o |=> mode_locked_o;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky)
    else $error("mode lock dropped before reset");
  property p_lock_on_ack;
    $rose(mode_locked_o) |-> sda_oe_o;
  endproperty
  a_lock_on_ack: assert property (p_lock_on_ack)
    else $error("mode lock set without an acked byte");
  property p_ref_frozen;
    mode_locked_o && $past(mode_locked_o, 3) |-> $stable(refs);
  endproperty
  a_ref_frozen: assert property (p_ref_frozen)
    else $error("mode setting changed after lock");
  // ======================================
  // Serial data line
  property p_ack_hold;
    $rose(sda_oe_o) |-> sda_oe_o[*4];
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("data line pull too short");
  property p_oe_scl_low;
    $changed(sda_oe_o) |-> !scl_i;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("data line changed while clock high");
endmodule
bind lcd_ctrl_top lcd_ctrl_monitor lcd_ctrl_monitor_inst (
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .scl_i(scl_i),
  .sda_oe_o(sda_oe_o), .segment_out_o(segment_out_o),
  .common_line_o(common_line_o), .ref_ext_div_o(ref_ext_div_o),
  .ref_int_div_o(ref_int_div_o), .ref_boost_o(ref_boost_o),
  .booster_run_o(booster_run_o), .mode_locked_o(mode_locked_o)
);
`default_nettype wire

// file: lcd_ctrl_top.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_ctrl_top (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic [lcd_pkg::NUM_SEG-1:0] segment_out_o,
  output logic [lcd_pkg::NUM_COM-1:0] common_line_o,
  output logic lcd_divided_clock_o,
  output logic ref_ext_div_o,
  output logic ref_int_div_o,
  output logic ref_boost_o,
  output logic booster_run_o,
  output logic [1:0] contrast_sel_o,
  output logic gain_o,
  output logic mode_locked_o
);
  // ==========================================
  // Reset release
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ==========================================
  // Declarations
  logic sel;
  logic sel_seg;
  logic sel_rd;
  logic wr;
  logic [7:0] wr_data;
  logic rd;
  logic [7:0] rd_data;
  logic sda_oe_int;

  logic [7:0] mode_setting_reg;
  logic [7:0] display_mode_reg;
  logic [7:0] clock_control_reg;
  logic [7:0] boost_control_reg;
  logic mode_locked;
  logic [3:0] disp_ram [lcd_pkg::NUM_SEG];

  logic space_seg;
  logic [7:0] reg_addr;
  logic addr_phase;
  logic [7:0] next_reg_addr;

  logic data_wr;
  logic we_mode;
  logic we_disp;
  logic we_clk;
  logic we_boost;
  logic ram_hit;
  logic [5:0] ram_idx;
  logic [7:0] ram_rd;

  logic display_enable;
  logic output_control;
  logic booster_enable;
  logic [2:0] mode_code;
  logic [1:0] ref_sel;
  logic [2:0] slices;
  logic lcd_tick;
  logic lcd_clk;
  logic [1:0] com_phase;
  logic [3:0] com_onehot;

  // ==========================================
  // Control space decode
  function automatic logic ctl_hit(input logic seg,
                                   input logic [7:0] addr,
                                   input logic [7:0] ofs);
    ctl_hit = !seg && (addr[1:0] == ofs[1:0]);
  endfunction

  // ==========================================
  // Serial link
  // slave ID selects space
  lcd_i2c_slave u_slave (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_oe_o(sda_oe_int),
    .sel_o(sel),
    .sel_seg_o(sel_seg),
    .sel_rd_o(sel_rd),
    .wr_o(wr),
    .wr_data_o(wr_data),
    .rd_o(rd),
    .rd_data_i(rd_data)
  );

  assign sda_oe_o = sda_oe_int;

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  // ==========================================
  // Register address pointer
  // address then auto-increment
  always_comb begin
    next_reg_addr = reg_addr;
    if (wr && addr_phase) begin
      next_reg_addr = wr_data;
    end else if (data_wr || rd) begin
      next_reg_addr = reg_addr + 8'h01;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      space_seg <= 1'b0;
      reg_addr <= 8'h00;
      addr_phase <= 1'b0;
    end else begin
      reg_addr <= next_reg_addr;
      if (sel) begin
        space_seg <= sel_seg;
        addr_phase <= !sel_rd;
      end else if (wr) begin
        addr_phase <= 1'b0;
      end
    end
  end

  // ==========================================
  // Write decode
  assign data_wr = wr && !addr_phase;
  assign we_mode = data_wr && !mode_locked &&
                   ctl_hit(space_seg, reg_addr, lcd_pkg::OFS_MODE);
  assign we_disp = data_wr &&
                   ctl_hit(space_seg, reg_addr, lcd_pkg::OFS_DISP);
  assign we_clk = data_wr &&
                  ctl_hit(space_seg, reg_addr, lcd_pkg::OFS_CLK);
  assign we_boost = data_wr &&
                    ctl_hit(space_seg, reg_addr, lcd_pkg::OFS_BOOST);
  assign ram_idx = reg_addr[5:0];
  assign ram_hit = space_seg && (reg_addr[5:0] <= lcd_pkg::OFS_RAM_LAST[5:0]);

  // ==========================================
  // Control registers
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_setting_reg <= lcd_pkg::RST_REG;
      mode_locked <= 1'b0;
      display_mode_reg <= lcd_pkg::RST_REG;
      clock_control_reg <= lcd_pkg::RST_REG;
      boost_control_reg <= lcd_pkg::RST_REG;
    end else begin
      if (we_mode) begin
        mode_setting_reg <= wr_data & lcd_pkg::MSK_MODE;
        mode_locked <= 1'b1;
      end
      if (we_disp) begin
        display_mode_reg <= wr_data & lcd_pkg::MSK_DISP;
      end
      if (we_clk) begin
        clock_control_reg <= wr_data & lcd_pkg::MSK_CLK;
      end
      if (we_boost) begin
        boost_control_reg <= wr_data & lcd_pkg::MSK_BOOST;
      end
    end
  end

  // ==========================================
  // Display RAM, one nibble per segment
  genvar gi;
  generate
    for (gi = 0; gi < lcd_pkg::NUM_SEG; gi = gi + 1) begin : g_ram
      always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
          disp_ram[gi] <= lcd_pkg::RST_RAM;
        end else if (data_wr && ram_hit && ram_idx == 6'(gi)) begin
          disp_ram[gi] <= wr_data[3:0] & lcd_pkg::MSK_RAM[3:0];
        end
      end
    end
  endgenerate

  // ==========================================
  // Read mux
  // upper nibble reads zero
  assign ram_rd = ram_hit ? {4'h0, disp_ram[ram_idx]} : 8'h00;

  always_comb begin
    if (space_seg) begin
      rd_data = ram_rd;
    end else begin
      case (reg_addr[1:0])
        lcd_pkg::OFS_MODE[1:0]: rd_data = mode_setting_reg;
        lcd_pkg::OFS_DISP[1:0]: rd_data = display_mode_reg;
        lcd_pkg::OFS_CLK[1:0]: rd_data = clock_control_reg;
        lcd_pkg::OFS_BOOST[1:0]: rd_data = boost_control_reg;
        default: rd_data = 8'h00;
      endcase
    end
  end

  // ==========================================
  // Field extraction
  assign display_enable = display_mode_reg[lcd_pkg::DISP_EN_BIT];
  assign output_control = display_mode_reg[lcd_pkg::OUT_CTL_BIT];
  assign booster_enable = display_mode_reg[lcd_pkg::BOOST_EN_BIT];
  assign mode_code = display_mode_reg[lcd_pkg::MODE_CODE_LSB +: 3];
  assign ref_sel = mode_setting_reg[lcd_pkg::REF_SEL_LSB +: 2];

  // ==========================================
  // LCD clock
  // 2^6..2^11 prescaler
  lcd_prescaler u_presc (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .src_sel_i(clock_control_reg[lcd_pkg::SRC_CLK_LSB +: 2]),
    .div_sel_i(clock_control_reg[lcd_pkg::DIV_SEL_LSB +: 2]),
    .tick_o(lcd_tick),
    .lcd_clk_o(lcd_clk)
  );

  // ==========================================
  // Time slices per mode; boost changes code 010
  assign slices = (mode_code == 3'h1 || mode_code == 3'h3) ? 3'h3 :
                  (mode_code == 3'h2) ? (ref_sel[1] ? 3'h4 : 3'h2) :
                  (mode_code == 3'h4) ? 3'h1 : 3'h4;

  assign com_onehot = 4'h1 << com_phase;

  // ==========================================
  // Scan and outputs
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      com_phase <= 2'h0;
      common_line_o <= 4'h0;
      lcd_divided_clock_o <= 1'b0;
      ref_ext_div_o <= 1'b0;
      ref_int_div_o <= 1'b0;
      ref_boost_o <= 1'b0;
      booster_run_o <= 1'b0;
      contrast_sel_o <= 2'h0;
      gain_o <= 1'b0;
      mode_locked_o <= 1'b0;
    end else begin
      if (lcd_tick) begin
        if ({1'b0, com_phase} >= slices - 3'h1) begin
          com_phase <= 2'h0;
        end else begin
          com_phase <= com_phase + 2'h1;
        end
      end
      common_line_o <= output_control ? com_onehot : 4'h0;
      lcd_divided_clock_o <= lcd_clk;
      ref_ext_div_o <= ref_sel == 2'b00;
      ref_int_div_o <= ref_sel == 2'b01;
      ref_boost_o <= ref_sel[1];
      booster_run_o <= booster_enable & ref_sel[1];
      contrast_sel_o <= boost_control_reg[lcd_pkg::CONTRAST_LSB +: 2];
      gain_o <= boost_control_reg[lcd_pkg::GAIN_BIT];
      mode_locked_o <= mode_locked;
    end
  end

  generate
    for (gi = 0; gi < lcd_pkg::NUM_SEG; gi = gi + 1) begin : g_seg
      always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
          segment_out_o[gi] <= 1'b0;
        end else begin
          segment_out_o[gi] <= display_enable & output_control &
                               disp_ram[gi][com_phase];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// file: lcd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_host_model (
  input wire logic mclk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  localparam int HALF = 3;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  // ======================================
  // Bus conditions and bits
  // start and stop
  task automatic start();
    sda_o = 1'b1;
    wt(HALF);
    scl_o = 1'b1;
    wt(HALF);
    sda_o = 1'b0;
    wt(HALF);
    scl_o = 1'b0;
  endtask
  task automatic stop();
    sda_o = 1'b0;
    wt(HALF);
    scl_o = 1'b1;
    wt(HALF);
    sda_o = 1'b1;
    wt(HALF);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_o = b;
    wt(HALF);
    scl_o = 1'b1;
    wt(HALF);
    r = sda_i;
    wt(HALF);
    scl_o = 1'b0;
    wt(HALF);
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic get_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~more, r);
  endtask
  // ======================================
  // Transfers
  // ID, address, auto-increment
  task automatic write_regs(input logic [6:0] id, input logic [7:0] a,
                            input logic [7:0] d[$], output logic ok);
    logic k;
    start();
    put_byte({id, 1'b0}, ok);
    if (ok) begin
      put_byte(a, k);
      foreach (d[i]) put_byte(d[i], k);
    end
    stop();
  endtask
  task automatic read_regs(input logic [6:0] id, input logic [7:0] a,
                           input int n, output logic [7:0] q[$]);
    logic k;
    logic [7:0] v;
    q = {};
    start();
    put_byte({id, 1'b0}, k);
    put_byte(a, k);
    start();
    put_byte({id, 1'b1}, k);
    for (int i = 0; i < n; i++) begin
      get_byte(i < n - 1, v);
      q.push_back(v);
    end
    stop();
  endtask
endmodule
`default_nettype wire

// file: lcd_i2c_slave.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_i2c_slave (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oe_o,
  output logic sel_o,
  output logic sel_seg_o,
  output logic sel_rd_o,
  output logic wr_o,
  output logic [7:0] wr_data_o,
  output logic rd_o,
  input wire logic [7:0] rd_data_i
);
  lcd_pkg::lcd_i2c_state_e state;
  logic scl_q;
  logic sda_q;
  logic [7:0] sh;
  logic [2:0] cnt;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic id_ok;

  assign scl_rise = scl_i & ~scl_q;
  assign scl_fall = ~scl_i & scl_q;
  assign start_c = scl_i & scl_q & sda_q & ~sda_i;
  assign stop_c = scl_i & scl_q & ~sda_q & sda_i;
  assign id_ok = sh[7:2] == lcd_pkg::ID_CTL[6:1];

  // ==========================================
  // Bit engine
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= lcd_pkg::LCD_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sh <= 8'h00;
      cnt <= 3'h0;
      sda_oe_o <= 1'b0;
      sel_o <= 1'b0;
      sel_seg_o <= 1'b0;
      sel_rd_o <= 1'b0;
      wr_o <= 1'b0;
      wr_data_o <= 8'h00;
      rd_o <= 1'b0;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      sel_o <= 1'b0;
      wr_o <= 1'b0;
      rd_o <= 1'b0;
      if (stop_c) begin
        state <= lcd_pkg::LCD_IDLE;
        sda_oe_o <= 1'b0;
      end else if (start_c) begin
        state <= lcd_pkg::LCD_ADDR;
        cnt <= 3'h0;
        sda_oe_o <= 1'b0;
      end else begin
        case (state)
          lcd_pkg::LCD_ADDR, lcd_pkg::LCD_RX: begin
            if (scl_rise) begin
              sh <= {sh[6:0], sda_i};
              cnt <= cnt + 3'h1;
              if (cnt == 3'h7) begin
                state <= (state == lcd_pkg::LCD_ADDR) ?
                         lcd_pkg::LCD_ADDR_END : lcd_pkg::LCD_RX_END;
              end
            end
          end
          lcd_pkg::LCD_ADDR_END: begin
            if (scl_fall) begin
              if (id_ok) begin
                sda_oe_o <= 1'b1;
                sel_o <= 1'b1;
                sel_seg_o <= sh[1];
                sel_rd_o <= sh[0];
                state <= lcd_pkg::LCD_ACK_A;
              end else begin
                state <= lcd_pkg::LCD_IDLE;
              end
            end
          end
          lcd_pkg::LCD_ACK_A, lcd_pkg::LCD_ACK_R: begin
            if (scl_fall) begin
              cnt <= 3'h0;
              if (sel_rd_o) begin
                sh <= rd_data_i;
                rd_o <= 1'b1;
                sda_oe_o <= ~rd_data_i[7];
                state <= lcd_pkg::LCD_TX;
              end else begin
                sda_oe_o <= 1'b0;
                state <= lcd_pkg::LCD_RX;
              end
            end
          end
          lcd_pkg::LCD_RX_END: begin
            if (scl_fall) begin
              sda_oe_o <= 1'b1;
              wr_o <= 1'b1;
              wr_data_o <= sh;
              state <= lcd_pkg::LCD_ACK_W;
            end
          end
          lcd_pkg::LCD_ACK_W: begin
            if (scl_fall) begin
              sda_oe_o <= 1'b0;
              cnt <= 3'h0;
              state <= lcd_pkg::LCD_RX;
            end
          end
          lcd_pkg::LCD_TX: begin
            if (scl_fall) begin
              if (cnt == 3'h7) begin
                sda_oe_o <= 1'b0;
                state <= lcd_pkg::LCD_TX_ACK;
              end else begin
                sh <= {sh[6:0], 1'b0};
                sda_oe_o <= ~sh[6];
                cnt <= cnt + 3'h1;
              end
            end
          end
          lcd_pkg::LCD_TX_ACK: begin
            if (scl_rise) begin
              state <= sda_i ? lcd_pkg::LCD_IDLE : lcd_pkg::LCD_ACK_R;
            end
          end
          default: begin
            state <= lcd_pkg::LCD_IDLE;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// file: lcd_pkg.sv
`default_nettype none
package lcd_pkg;
  // ==========================================
  // Geometry
  localparam int NUM_SEG = 40;
  localparam int NUM_COM = 4;

  // ==========================================
  // Serial slave IDs (7 bits)
  localparam logic [6:0] ID_CTL = 7'h38;
  localparam logic [6:0] ID_SEG = 7'h39;

  // ==========================================
  // Control space offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_DISP = 8'h01;
  localparam logic [7:0] OFS_CLK = 8'h02;
  localparam logic [7:0] OFS_BOOST = 8'h03;
  // Segment space last offset
  localparam logic [7:0] OFS_RAM_LAST = 8'h27;

  // ==========================================
  // Reset values and writable-bit masks
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [3:0] RST_RAM = 4'h0;
  localparam logic [7:0] MSK_MODE = 8'hE3;
  localparam logic [7:0] MSK_DISP = 8'hE7;
  localparam logic [7:0] MSK_CLK = 8'h0F;
  localparam logic [7:0] MSK_BOOST = 8'hC1;
  localparam logic [7:0] MSK_RAM = 8'h0F;

  // ==========================================
  // Field positions
  localparam int SEG_CNT_LSB = 5;
  localparam int REF_SEL_LSB = 0;
  localparam int DISP_EN_BIT = 7;
  localparam int OUT_CTL_BIT = 6;
  localparam int BOOST_EN_BIT = 5;
  localparam int MODE_CODE_LSB = 0;
  localparam int SRC_CLK_LSB = 2;
  localparam int DIV_SEL_LSB = 0;
  localparam int CONTRAST_LSB = 6;
  localparam int GAIN_BIT = 0;

  // ==========================================
  // Prescaler: smallest ratio is 2^6
  localparam logic [3:0] PRESC_BASE = 4'h6;
  localparam int PRESC_W = 11;

  // ==========================================
  // Serial slave states
  typedef enum logic [3:0] {
    LCD_IDLE = 4'b0000,
    LCD_ADDR = 4'b0001,
    LCD_ADDR_END = 4'b0010,
    LCD_ACK_A = 4'b0011,
    LCD_RX = 4'b0100,
    LCD_RX_END = 4'b0101,
    LCD_ACK_W = 4'b0110,
    LCD_TX = 4'b0111,
    LCD_TX_ACK = 4'b1000,
    LCD_ACK_R = 4'b1001
  } lcd_i2c_state_e;
endpackage
`default_nettype wire

// file: lcd_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_prescaler (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] src_sel_i,
  input wire logic [1:0] div_sel_i,
  output logic tick_o,
  output logic lcd_clk_o
);
  logic [lcd_pkg::PRESC_W-1:0] cnt;
  logic [3:0] src_shift;
  logic [3:0] shift;
  logic [lcd_pkg::PRESC_W-1:0] mask;
  logic [lcd_pkg::PRESC_W-1:0] top_bit;

  // ==========================================
  // Ratio select: source /1,/2,/4 then /2^6../2^9
  assign src_shift = src_sel_i[1] ? {3'b000, 1'b1} + {3'b000, src_sel_i[0]}
                                  : 4'h0;
  assign shift = lcd_pkg::PRESC_BASE + src_shift + {2'b00, div_sel_i};
  assign mask = ~({lcd_pkg::PRESC_W{1'b1}} << shift);
  assign top_bit = mask ^ (mask >> 1);

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= '0;
      tick_o <= 1'b0;
      lcd_clk_o <= 1'b0;
    end else begin
      cnt <= cnt + 1'b1;
      tick_o <= (cnt & mask) == mask;
      lcd_clk_o <= |(cnt & top_bit);
    end
  end
endmodule
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk_i;
  logic rst_b_i;
  wire scl, host_sda, sda_oe, ref_e, ref_i, ref_b, run, gain, locked;
  wire sdo, lclk;
  wire sda_bus;
  wire [39:0] seg;
  wire [3:0] com;
  wire [1:0] ctr;
  int fails;
  int check_count;
  assign sda_bus = host_sda & ~sda_oe;
  lcd_ctrl_top lcd_ctrl_top_inst (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda_bus),
    .sda_o(sdo), .sda_oe_o(sda_oe), .segment_out_o(seg),
    .common_line_o(com), .lcd_divided_clock_o(lclk),
    .ref_ext_div_o(ref_e), .ref_int_div_o(ref_i), .ref_boost_o(ref_b),
    .booster_run_o(run), .contrast_sel_o(ctr), .gain_o(gain),
    .mode_locked_o(locked)
  );
  lcd_host_model lcd_host_model_inst (
    .mclk_i(mclk_i), .sda_i(sda_bus), .scl_o(scl), .sda_o(host_sda)
  );
  initial mclk_i = 1'b0;
  always #5 mclk_i = ~mclk_i;
  // ======================================
  // Helpers
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic do_reset();
    rst_b_i = 1'b0;
    repeat (4) @(negedge mclk_i);
    rst_b_i = 1'b1;
    repeat (4) @(negedge mclk_i);
  endtask
  task automatic wr(input logic [6:0] id, input logic [7:0] a,
                    input logic [7:0] d[$]);
    logic ok;
    lcd_host_model_inst.write_regs(id, a, d, ok);
    chk(ok, id < 7'h3A);
  endtask
  task automatic rd_chk(input logic [6:0] id, input logic [7:0] a,
                        input logic [7:0] e[$]);
    logic [7:0] q[$];
    lcd_host_model_inst.read_regs(id, a, e.size(), q);
    foreach (e[i]) chk(q[i], e[i]);
  endtask
  task automatic gap(input logic sel, output int n);
    logic [3:0] p;
    p = sel ? {3'h0, lclk} : com;
    n = 0;
    while ((sel ? {3'h0, lclk} : com) === p && n < 5000) begin
      @(negedge mclk_i);
      n++;
    end
  endtask
  function automatic logic [2:0] exp_ref(input logic [1:0] c);
    return c[1] ? 3'b001 : (c[0] ? 3'b010 : 3'b100);
  endfunction
  function automatic logic [7:0] msk(input logic [7:0] a);
    case (a)
      8'h01: return lcd_pkg::MSK_DISP;
      8'h02: return lcd_pkg::MSK_CLK;
      default: return lcd_pkg::MSK_BOOST;
    endcase
  endfunction
  function automatic int ratio(input logic [3:0] v);
    return (64 << v[1:0]) * (v[3] ? (v[2] ? 4 : 2) : 1);
  endfunction
  // ======================================
  // Tests
  initial begin
    logic [7:0] d[$];
    logic [7:0] ram[$];
    logic [7:0] m;
    logic [1:0] c;
    logic [39:0] e;
    logic [3:0] cs [4];
    int n;
    rst_b_i = 1'b0;
    void'($urandom(32'h541F));
    for (int k = 3; k >= 0; k--) begin
      c = 2'(k);
      do_reset();
      rd_chk(lcd_pkg::ID_CTL, 8'h00, '{8'h00});
      chk(locked, 1'b0);
      m = {2'b00, 1'($urandom), 3'b000, c};
      wr(lcd_pkg::ID_CTL, 8'h00, '{m, 8'h20});
      chk({ref_e, ref_i, ref_b}, exp_ref(c));
      chk(run, c[1]);
      chk(locked, 1'b1);
      wr(lcd_pkg::ID_CTL, 8'h00, '{m ^ 8'h02});
      rd_chk(lcd_pkg::ID_CTL, 8'h00, '{m});
    end
    d = '{8'($urandom), 8'($urandom), 8'($urandom)};
    wr(lcd_pkg::ID_CTL, 8'h01, d);
    rd_chk(lcd_pkg::ID_CTL, 8'h01, '{d[0] & msk(8'h01),
           d[1] & msk(8'h02), d[2] & msk(8'h03)});
    chk(ctr, d[2][7:6]);
    chk(gain, d[2][0]);
    wr(7'h3A, 8'h00, '{8'h00});
    ram = {};
    for (int i = 0; i < 40; i++) ram.push_back(8'($urandom));
    ram[39] = 8'hFF;
    wr(lcd_pkg::ID_SEG, 8'h00, ram);
    d = {};
    foreach (ram[i]) d.push_back(ram[i] & 8'h0F);
    rd_chk(lcd_pkg::ID_SEG, 8'h00, d);
    wr(lcd_pkg::ID_SEG, 8'h28, '{8'h5A});
    rd_chk(lcd_pkg::ID_SEG, 8'h28, '{8'h00});
    rd_chk(lcd_pkg::ID_CTL, 8'h00, '{m});
    chk(sdo, 1'b0);
    wr(lcd_pkg::ID_CTL, 8'h01, '{8'hC4, 8'h00});
    repeat (2 * ratio(4'h0)) @(negedge mclk_i);
    foreach (ram[i]) e[i] = ram[i][0];
    chk(com, 4'b0001);
    chk(seg, e);
    wr(lcd_pkg::ID_CTL, 8'h01, '{8'h40});
    chk(seg, 40'h0);
    cs = '{4'h0, 4'h5, 4'hA, 4'hF};
    foreach (cs[j]) begin
      wr(lcd_pkg::ID_CTL, 8'h02, '{8'(cs[j])});
      gap(1'b0, n);
      gap(1'b0, n);
      chk(n, ratio(cs[j]));
      gap(1'b1, n);
      gap(1'b1, n);
      chk(n, ratio(cs[j]) / 2);
    end
    // Three and two time slices
    wr(lcd_pkg::ID_CTL, 8'h01, '{8'h41});
    gap(1'b0, n);
    cs[0] = com;
    repeat (3) gap(1'b0, n);
    chk(com, cs[0]);
    wr(lcd_pkg::ID_CTL, 8'h01, '{8'h42});
    gap(1'b0, n);
    cs[0] = com;
    repeat (2) gap(1'b0, n);
    chk(com, cs[0]);
    test_done();
  end
  initial begin
    repeat (90000) @(posedge mclk_i);
    fails++;
    test_done();
  end
endmodule
`default_nettype wire
